// [rtl/lrm_pkg.sv]
package lrm_pkg;
  localparam int LRM_NUM_LDO = 9;
  localparam int LRM_NUM_BUCK = 4;
  localparam int LRM_LVL_W = 8;
  localparam int LRM_CNT_W = 17;

  typedef enum logic [1:0] {
    LRM_MODE_NORMAL = 2'b00,
    LRM_MODE_GROUP = 2'b01,
    LRM_MODE_LOW = 2'b10,
    LRM_MODE_FULL = 2'b11
  } lrm_mode_t;

  typedef enum logic [1:0] {
    LRM_ST_IDLE = 2'b00,
    LRM_ST_WAIT_BIAS = 2'b01,
    LRM_ST_TURN_ON = 2'b10,
    LRM_ST_RUN = 2'b11
  } lrm_state_t;

  // Register byte offsets
  localparam logic [7:0] LRM_OFS_CTRL = 8'h00;
  localparam logic [7:0] LRM_OFS_LDO_MODE = 8'h04;
  localparam logic [7:0] LRM_OFS_BUCK_MODE = 8'h08;
  localparam logic [7:0] LRM_OFS_SEQ_SLOT = 8'h0c;
  localparam logic [7:0] LRM_OFS_SW_EN = 8'h10;
  localparam logic [7:0] LRM_OFS_SLEW = 8'h14;
  localparam logic [7:0] LRM_OFS_CLAMP = 8'h18;
  localparam logic [7:0] LRM_OFS_IRQ_FLAGS = 8'h1c;
  localparam logic [7:0] LRM_OFS_TOP_IRQ = 8'h20;
  localparam logic [7:0] LRM_OFS_TOP_MASK = 8'h24;
  localparam logic [7:0] LRM_OFS_STATUS = 8'h28;
  localparam logic [7:0] LRM_OFS_TARGET = 8'h40;

  // Control register bit positions
  localparam int LRM_CTRL_FORCE_BIAS = 0;
  localparam int LRM_CTRL_GLOBAL_LP = 1;
  localparam int LRM_CTRL_LP_FROM_PIN = 2;

  // Values after reset
  localparam logic [2:0] LRM_RST_CTRL = 3'h0;
  localparam logic [8:0] LRM_RST_CLAMP = 9'h1ff;
  localparam logic LRM_RST_TOP_MASK = 1'b1;
  localparam logic [7:0] LRM_RST_TARGET = 8'h00;

  // Timing
  localparam int LRM_CLK_PERIOD_NS = 40;
  localparam int LRM_CLK_KHZ = 25000;
  localparam int LRM_POK_FILT_NS = 25000;
  localparam int LRM_POK_FILT_CYC = (LRM_POK_FILT_NS + LRM_CLK_PERIOD_NS - 1) / LRM_CLK_PERIOD_NS;
  localparam int LRM_BIAS_ON_NS = 50000;
  localparam int LRM_BIAS_ON_CYC = (LRM_BIAS_ON_NS + LRM_CLK_PERIOD_NS - 1) / LRM_CLK_PERIOD_NS;
  localparam int LRM_LDO_ON_NS = 20000;
  localparam int LRM_LDO_ON_CYC = (LRM_LDO_ON_NS + LRM_CLK_PERIOD_NS - 1) / LRM_CLK_PERIOD_NS;
  localparam int LRM_STEP_UV = 25000;
  localparam int LRM_SLEW_SLOW_UV_PER_MS = 5000;
  localparam int LRM_SLEW_FAST_UV_PER_MS = 100000;
  localparam int LRM_STEP_SLOW_CYC =
    (LRM_STEP_UV * LRM_CLK_KHZ + LRM_SLEW_SLOW_UV_PER_MS - 1) / LRM_SLEW_SLOW_UV_PER_MS;
  localparam int LRM_STEP_FAST_CYC =
    (LRM_STEP_UV * LRM_CLK_KHZ + LRM_SLEW_FAST_UV_PER_MS - 1) / LRM_SLEW_FAST_UV_PER_MS;
endpackage : lrm_pkg

// [rtl/lrm_pok_filter.sv]
`timescale 1ns/100ps
module lrm_pok_filter (
  input wire logic clock_in,  // System clock
  input wire logic reset_in,  // Sync reset, high
  input wire logic enable_in,  // Clock enable
  input wire logic raw_in,  // Synchronised comparator level
  output logic good_out,  // Filtered power good
  output logic fall_out  // One-cycle pulse on accepted fall
);
  import lrm_pkg::*;

  localparam logic [9:0] FILT_LAST = 10'(LRM_POK_FILT_CYC - 1);

  logic good_q;
  logic fall_q;
  logic [9:0] cnt_q;
  wire differ = raw_in != good_q;
  wire accept = differ && (cnt_q == FILT_LAST);

  // Level must differ for the full window before it is taken
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      good_q <= 1'b0;
      fall_q <= 1'b0;
      cnt_q <= 10'h000;
    end else if (enable_in) begin
      cnt_q <= (differ && !accept) ? cnt_q + 10'h001 : 10'h000;
      if (accept) begin
        good_q <= raw_in;
      end
      fall_q <= accept && !raw_in;
    end
  end

  assign good_out = good_q;
  assign fall_out = fall_q;
endmodule : lrm_pok_filter

// [rtl/lrm_ramp.sv]
`timescale 1ns/100ps
module lrm_ramp #(
  parameter int STEP_SLOW_CYC = lrm_pkg::LRM_STEP_SLOW_CYC,  // Cycles per step, slow
  parameter int STEP_FAST_CYC = lrm_pkg::LRM_STEP_FAST_CYC  // Cycles per step, fast
) (
  input wire logic clock_in,  // System clock
  input wire logic reset_in,  // Sync reset, high
  input wire logic enable_in,  // Clock enable
  input wire logic ldo_on_in,  // Effective regulator enable
  input wire logic bias_ready_in,  // Bias has finished turning on
  input wire logic fast_in,  // Slew select, 1 = fast
  input wire logic [lrm_pkg::LRM_LVL_W-1:0] target_in,  // Target level code
  input wire logic [lrm_pkg::LRM_LVL_W-1:0] start_in,  // Sensed output level
  output logic on_out,  // Regulator pass device on
  output logic ramping_out,  // Level differs from target while on
  output logic [lrm_pkg::LRM_LVL_W-1:0] level_out  // Present setpoint code
);
  import lrm_pkg::*;

  localparam logic [LRM_CNT_W-1:0] ON_LAST = LRM_CNT_W'(LRM_LDO_ON_CYC - 1);
  localparam logic [LRM_CNT_W-1:0] SLOW_LAST = LRM_CNT_W'(STEP_SLOW_CYC - 1);
  localparam logic [LRM_CNT_W-1:0] FAST_LAST = LRM_CNT_W'(STEP_FAST_CYC - 1);

  lrm_state_t state_q, state_d;
  logic [LRM_CNT_W-1:0] cnt_q, cnt_d;
  logic [LRM_LVL_W-1:0] level_q, level_d;
  logic on_q;

  wire [LRM_CNT_W-1:0] step_last = fast_in ? FAST_LAST : SLOW_LAST;
  wire at_target = level_q == target_in;
  wire step_due = cnt_q >= step_last;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + LRM_CNT_W'(1);
    level_d = level_q;
    unique case (state_q)
      LRM_ST_IDLE: begin
        cnt_d = '0;
        if (ldo_on_in) begin
          level_d = start_in;
          state_d = bias_ready_in ? LRM_ST_TURN_ON : LRM_ST_WAIT_BIAS;
        end
      end
      LRM_ST_WAIT_BIAS: begin
        cnt_d = '0;
        if (!ldo_on_in) begin
          state_d = LRM_ST_IDLE;
        end else if (bias_ready_in) begin
          state_d = LRM_ST_TURN_ON;
        end
      end
      LRM_ST_TURN_ON: begin
        if (!ldo_on_in) begin
          state_d = LRM_ST_IDLE;
        end else if (cnt_q == ON_LAST) begin
          state_d = LRM_ST_RUN;
          cnt_d = '0;
        end
      end
      LRM_ST_RUN: begin
        if (!ldo_on_in) begin
          state_d = LRM_ST_IDLE;
        end else if (at_target) begin
          cnt_d = '0;
        end else if (step_due) begin
          cnt_d = '0;
          // One code step either way at the chosen pace
          level_d = (level_q < target_in) ? level_q + LRM_LVL_W'(1)
                                          : level_q - LRM_LVL_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= LRM_ST_IDLE;
      cnt_q <= '0;
      level_q <= '0;
      on_q <= 1'b0;
    end else if (enable_in) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
      on_q <= state_d == LRM_ST_RUN;
    end
  end

  assign on_out = on_q;
  assign level_out = level_q;
  assign ramping_out = on_q && !at_target;
endmodule : lrm_ramp

// [rtl/lrm_top.sv]
`timescale 1ns/100ps
module lrm_top #(
  parameter int STEP_SLOW_CYC = lrm_pkg::LRM_STEP_SLOW_CYC,  // Slow slew step cycles
  parameter int STEP_FAST_CYC = lrm_pkg::LRM_STEP_FAST_CYC  // Fast slew step cycles
) (
  input wire logic clock_in,  // 25 MHz clock
  input wire logic reset_in,  // Sync reset, high
  input wire logic clk_en_in,  // Freezes all state when low
  input wire logic [7:0] avs_address_in,  // Avalon byte address
  input wire logic avs_read_in,  // Avalon read
  input wire logic avs_write_in,  // Avalon write
  input wire logic [31:0] avs_writedata_in,  // Avalon write data
  output logic [31:0] avs_readdata_out,  // Avalon read data
  output logic avs_waitrequest_out,  // Avalon wait request
  input wire logic general_pin_zero_in,  // Pin zero, async
  input wire logic [lrm_pkg::LRM_NUM_LDO-1:0] ldo_power_good_in,  // Comparators, async
  input wire logic [lrm_pkg::LRM_NUM_LDO-1:0][lrm_pkg::LRM_LVL_W-1:0] ldo_sense_in,  // Out level
  input wire logic [lrm_pkg::LRM_NUM_LDO-1:0] seq_enable_in,  // Sequencer enables
  output logic bias_out,  // Regulator bias enable
  output logic global_bias_out,  // Global bias enable
  output logic [lrm_pkg::LRM_NUM_LDO-1:0] ldo_on_out,  // Regulator on
  output logic [lrm_pkg::LRM_NUM_LDO-1:0][lrm_pkg::LRM_LVL_W-1:0] ldo_level_out,  // Setpoint
  output logic [lrm_pkg::LRM_NUM_LDO-1:0] ldo_low_power_out,  // Regulator in low power
  output logic [lrm_pkg::LRM_NUM_LDO-1:0] ldo_clamp_out,  // Overvoltage clamp on
  output logic [lrm_pkg::LRM_NUM_BUCK-1:0] buck_low_power_out,  // Step-down low power
  output logic ldo_summary_irq_out  // Summary interrupt gated by the top mask, high
);
  import lrm_pkg::*;

  localparam int NL = LRM_NUM_LDO;
  localparam int NB = LRM_NUM_BUCK;
  localparam int SYNC_W = 1 + NL + NL * LRM_LVL_W;
  // Shares the ramp counter width, which covers the slowest slew step
  localparam logic [LRM_CNT_W-1:0] BIAS_LAST = LRM_CNT_W'(LRM_BIAS_ON_CYC - 1);

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = addr == ofs;
  endfunction : reg_hit

  function automatic logic mode_low(input logic [1:0] mode, input logic global_lp);
    mode_low = (mode == LRM_MODE_LOW) || ((mode == LRM_MODE_GROUP) && global_lp);
  endfunction : mode_low

  // Software registers
  logic [2:0] ctrl_q;
  logic [NL-1:0][1:0] ldo_power_mode_sel_q;
  logic [NB-1:0][1:0] buck_power_mode_sel_q;
  logic [NL-1:0] ldo_sequencer_slot_q;
  logic [NL-1:0] sw_en_q;
  logic [NL-1:0] ldo_slew_select_q;
  logic [NL-1:0] ldo_clamp_enable_q;
  logic [NL-1:0] ldo_block_irq_flags_q, ldo_block_irq_flags_d;
  logic top_mask_q;
  logic [NL-1:0][LRM_LVL_W-1:0] target_q;

  // Bus slave state
  logic wait_q;
  logic [31:0] rdata_q, rdata_d;

  // Pin synchroniser, three stages
  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q, stable_q;

  // Bias and output state
  logic bias_q, global_bias_q, bias_ready_q;
  logic [LRM_CNT_W-1:0] bias_cnt_q;
  logic [NL-1:0] low_q, clamp_q;
  logic [NB-1:0] buck_low_q;
  logic irq_q;

  wire [SYNC_W-1:0] sync_raw = {general_pin_zero_in, ldo_power_good_in, ldo_sense_in};
  wire pin_zero = stable_q[SYNC_W-1];
  wire [NL-1:0] pok_sync = stable_q[NL*LRM_LVL_W +: NL];
  wire [NL-1:0][LRM_LVL_W-1:0] sense_sync = stable_q[NL*LRM_LVL_W-1:0];

  // Single-bit levels settle bit by bit; sense codes move as whole words
  wire [SYNC_W-1:0] stable_d;
  wire [NL:0] lvl2 = sync2_q[SYNC_W-1 -: NL+1];
  wire [NL:0] lvl3 = sync3_q[SYNC_W-1 -: NL+1];
  wire [NL:0] lvl_old = stable_q[SYNC_W-1 -: NL+1];
  assign stable_d[SYNC_W-1 -: NL+1] = (lvl2 & lvl3) | (lvl_old & (lvl2 | lvl3));

  wire bus_req = avs_read_in || avs_write_in;
  wire bus_ack = bus_req && !wait_q;
  wire wr_go = bus_ack && avs_write_in && clk_en_in;
  wire [7:0] addr = avs_address_in;
  // Targets sit one word apart; unaligned addresses read as zero
  wire tgt_hit = (addr >= LRM_OFS_TARGET) && (addr < LRM_OFS_TARGET + 8'(4 * NL))
                 && (addr[1:0] == 2'b00);
  wire [3:0] tgt_idx = 4'((addr - LRM_OFS_TARGET) >> 2);

  // Write strobes, one per register and one shared by all targets; flag clears decode below
  wire wr_target = wr_go && tgt_hit;
  wire wr_ctrl = wr_go && reg_hit(addr, LRM_OFS_CTRL);
  wire wr_ldo_mode = wr_go && reg_hit(addr, LRM_OFS_LDO_MODE);
  wire wr_buck_mode = wr_go && reg_hit(addr, LRM_OFS_BUCK_MODE);
  wire wr_seq_slot = wr_go && reg_hit(addr, LRM_OFS_SEQ_SLOT);
  wire wr_sw_en = wr_go && reg_hit(addr, LRM_OFS_SW_EN);
  wire wr_slew = wr_go && reg_hit(addr, LRM_OFS_SLEW);
  wire wr_clamp = wr_go && reg_hit(addr, LRM_OFS_CLAMP);
  wire wr_top_mask = wr_go && reg_hit(addr, LRM_OFS_TOP_MASK);

  // Pin source lags the register bit by the synchroniser's cycles
  wire global_lp = ctrl_q[LRM_CTRL_LP_FROM_PIN] ? pin_zero : ctrl_q[LRM_CTRL_GLOBAL_LP];
  wire [NL-1:0] eff_en;
  wire [NL-1:0] low_d;
  wire [NB-1:0] buck_low_d;
  wire [NL-1:0] ldo_on, ramping, pok_good, pok_fall;
  wire [NL-1:0][LRM_LVL_W-1:0] level;
  wire bias_d = ctrl_q[LRM_CTRL_FORCE_BIAS] || (|eff_en);
  wire summary = |ldo_block_irq_flags_q;
  // Clamp ignores the enable state, so an off regulator keeps its setting
  wire [NL-1:0] clamp_d = ldo_clamp_enable_q & ~low_d;

  // Flags clear by writing one; a new fall in the same cycle wins
  wire [NL-1:0] flag_clr = (wr_go && reg_hit(addr, LRM_OFS_IRQ_FLAGS))
                           ? avs_writedata_in[NL-1:0] : '0;
  assign ldo_block_irq_flags_d = (ldo_block_irq_flags_q & ~flag_clr) | pok_fall;

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_ldo
      // Slot hands only the enable to the sequencer; mode stays with software
      assign eff_en[gi] = ldo_sequencer_slot_q[gi] ? seq_enable_in[gi] : sw_en_q[gi];
      assign low_d[gi] = mode_low(ldo_power_mode_sel_q[gi], global_lp);

      // A code caught mid-change is held off until both late stages agree
      assign stable_d[gi*LRM_LVL_W +: LRM_LVL_W] =
        (sync2_q[gi*LRM_LVL_W +: LRM_LVL_W] == sync3_q[gi*LRM_LVL_W +: LRM_LVL_W])
        ? sync3_q[gi*LRM_LVL_W +: LRM_LVL_W] : stable_q[gi*LRM_LVL_W +: LRM_LVL_W];

      lrm_ramp #(
        .STEP_SLOW_CYC(STEP_SLOW_CYC),
        .STEP_FAST_CYC(STEP_FAST_CYC)
      ) u_ramp (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(clk_en_in),
        .ldo_on_in(eff_en[gi]),
        .bias_ready_in(bias_ready_q),
        .fast_in(ldo_slew_select_q[gi]),
        .target_in(target_q[gi]),
        .start_in(sense_sync[gi]),
        .on_out(ldo_on[gi]),
        .ramping_out(ramping[gi]),
        .level_out(level[gi])
      );

      lrm_pok_filter u_pok (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(clk_en_in),
        .raw_in(pok_sync[gi]),
        .good_out(pok_good[gi]),
        .fall_out(pok_fall[gi])
      );
    end
    // Step-down fields only pick low power; the regulators live elsewhere
    for (gi = 0; gi < NB; gi++) begin : g_buck
      assign buck_low_d[gi] = mode_low(buck_power_mode_sel_q[gi], global_lp);
    end
  endgenerate

  // Read mux, captured on the wait cycle so data stands at the ack edge
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (tgt_hit) begin
      rdata_d[LRM_LVL_W-1:0] = target_q[tgt_idx];
    end else begin
      unique case (addr)
        LRM_OFS_CTRL: rdata_d[2:0] = ctrl_q;
        LRM_OFS_LDO_MODE: rdata_d[2*NL-1:0] = ldo_power_mode_sel_q;
        LRM_OFS_BUCK_MODE: rdata_d[2*NB-1:0] = buck_power_mode_sel_q;
        LRM_OFS_SEQ_SLOT: rdata_d[NL-1:0] = ldo_sequencer_slot_q;
        LRM_OFS_SW_EN: rdata_d[NL-1:0] = sw_en_q;
        LRM_OFS_SLEW: rdata_d[NL-1:0] = ldo_slew_select_q;
        LRM_OFS_CLAMP: rdata_d[NL-1:0] = ldo_clamp_enable_q;
        LRM_OFS_IRQ_FLAGS: rdata_d[NL-1:0] = ldo_block_irq_flags_q;
        LRM_OFS_TOP_IRQ: rdata_d[0] = summary;
        LRM_OFS_TOP_MASK: rdata_d[0] = top_mask_q;
        LRM_OFS_STATUS: rdata_d[2*NL+1:0] = {global_lp, bias_ready_q, ramping, pok_good};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus handshake: one wait cycle, then acknowledge
  // Fixed latency, no error response: unmapped reads give zero
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      wait_q <= !(bus_req && wait_q);
      if (bus_req && wait_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_q <= LRM_RST_CTRL;
      ldo_power_mode_sel_q <= '0;
      buck_power_mode_sel_q <= '0;
      ldo_sequencer_slot_q <= '0;
      sw_en_q <= '0;
      ldo_slew_select_q <= '0;
      ldo_clamp_enable_q <= LRM_RST_CLAMP;
      top_mask_q <= LRM_RST_TOP_MASK;
      target_q <= {NL{LRM_RST_TARGET}};
    end else if (wr_go) begin
      // Writes land on the acknowledge edge only
      if (wr_target) begin
        target_q[tgt_idx] <= avs_writedata_in[LRM_LVL_W-1:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= avs_writedata_in[2:0];
      end
      if (wr_ldo_mode) begin
        ldo_power_mode_sel_q <= avs_writedata_in[2*NL-1:0];
      end
      if (wr_buck_mode) begin
        buck_power_mode_sel_q <= avs_writedata_in[2*NB-1:0];
      end
      if (wr_seq_slot) begin
        ldo_sequencer_slot_q <= avs_writedata_in[NL-1:0];
      end
      if (wr_sw_en) begin
        sw_en_q <= avs_writedata_in[NL-1:0];
      end
      if (wr_slew) begin
        ldo_slew_select_q <= avs_writedata_in[NL-1:0];
      end
      if (wr_clamp) begin
        ldo_clamp_enable_q <= avs_writedata_in[NL-1:0];
      end
      if (wr_top_mask) begin
        top_mask_q <= avs_writedata_in[0];
      end
    end
  end

  // Agreement of stages two and three filters one-cycle metastable glitches
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      stable_q <= '0;
    end else if (clk_en_in) begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      stable_q <= stable_d;
    end
  end

  // Bias counts its turn-on time; ramps wait on bias_ready
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      bias_q <= 1'b0;
      global_bias_q <= 1'b0;
      bias_ready_q <= 1'b0;
      bias_cnt_q <= '0;
    end else if (clk_en_in) begin
      bias_q <= bias_d;
      global_bias_q <= bias_d;
      if (!bias_q) begin
        bias_cnt_q <= '0;
        bias_ready_q <= 1'b0;
      end else if (!bias_ready_q) begin
        bias_cnt_q <= bias_cnt_q + LRM_CNT_W'(1);
        bias_ready_q <= bias_cnt_q == BIAS_LAST;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      low_q <= '0;
      clamp_q <= '0;
      buck_low_q <= '0;
      ldo_block_irq_flags_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en_in) begin
      low_q <= low_d;
      clamp_q <= clamp_d;
      buck_low_q <= buck_low_d;
      ldo_block_irq_flags_q <= ldo_block_irq_flags_d;
      // Mask gates only the pin; flags keep recording underneath
      irq_q <= summary && !top_mask_q;
    end
  end

  // Every output is a flop, here or inside a submodule
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign bias_out = bias_q;
  assign global_bias_out = global_bias_q;
  assign ldo_on_out = ldo_on;
  assign ldo_level_out = level;
  assign ldo_low_power_out = low_q;
  assign ldo_clamp_out = clamp_q;
  assign buck_low_power_out = buck_low_q;
  assign ldo_summary_irq_out = irq_q;
endmodule : lrm_top

// [dv/lrm_properties.sv]
`timescale 1ns/100ps
module lrm_checker (
  input wire logic clock_in,  // Clock
  input wire logic reset_in,  // Reset
  input wire logic avs_read_in,  // Read
  input wire logic avs_write_in,  // Write
  input wire logic avs_waitrequest_out,  // Wait
  input wire logic bias_out,  // Bias
  input wire logic global_bias_out,  // Global bias
  input wire logic [lrm_pkg::LRM_NUM_LDO-1:0] ldo_on_out,  // On
  input wire logic [lrm_pkg::LRM_NUM_LDO-1:0][lrm_pkg::LRM_LVL_W-1:0] ldo_level_out,  // Level
  input wire logic [lrm_pkg::LRM_NUM_LDO-1:0] ldo_low_power_out,  // Low power
  input wire logic [lrm_pkg::LRM_NUM_LDO-1:0] ldo_clamp_out,  // Clamp
  input wire logic ldo_summary_irq_out  // Summary irq
);
  import lrm_pkg::*;
  logic [10:0] bias_cnt_q;
  // Saturates, so a long bias-on spell cannot wrap into a false early count
  always_ff @(posedge clock_in) begin
    if (reset_in || !bias_out) begin
      bias_cnt_q <= 11'h000;
    end else if (bias_cnt_q != 11'h7ff) begin
      bias_cnt_q <= bias_cnt_q + 11'h001;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_bias_global; bias_out |-> global_bias_out; endproperty
  property p_on_bias; ldo_on_out != 9'h000 |-> bias_out; endproperty
  property p_clamp_lp; (ldo_clamp_out & ldo_low_power_out) == 9'h000; endproperty
  property p_on_late;
    (ldo_on_out & ~$past(ldo_on_out)) != 9'h000 |-> bias_cnt_q >= 11'(LRM_BIAS_ON_CYC);
  endproperty
  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  property p_wait_pulse; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  property p_step;
    ldo_on_out[0] && $past(ldo_on_out[0]) && $changed(ldo_level_out[0]) |->
      (ldo_level_out[0] - $past(ldo_level_out[0]) == 8'h01) ||
      ($past(ldo_level_out[0]) - ldo_level_out[0] == 8'h01);
  endproperty
  property p_step_gap;
    ldo_on_out[0] && $changed(ldo_level_out[0]) |=>
      ($stable(ldo_level_out[0]) || !ldo_on_out[0]) [*2];
  endproperty
  a_bias_global: assert property (p_bias_global) else $error("global bias off");
  a_on_bias: assert property (p_on_bias) else $error("regulator on without bias");
  a_clamp_lp: assert property (p_clamp_lp) else $error("clamp on in low power");
  a_on_late: assert property (p_on_late) else $error("regulator on too early");
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
  a_wait_pulse: assert property (p_wait_pulse) else $error("ack held too long");
  a_step: assert property (p_step) else $error("level jumped");
  a_step_gap: assert property (p_step_gap) else $error("level stepped too fast");
  c_irq: cover property (ldo_summary_irq_out);
  c_on: cover property ($rose(ldo_on_out[0]));
  c_lp: cover property (ldo_low_power_out == 9'h1ff);
endmodule : lrm_checker

bind lrm_top lrm_checker u_lrm_checker (.clock_in, .reset_in, .avs_read_in, .avs_write_in,
  .avs_waitrequest_out, .bias_out, .global_bias_out, .ldo_on_out, .ldo_level_out,
  .ldo_low_power_out, .ldo_clamp_out, .ldo_summary_irq_out);

// [dv/lrm_top_tb_top.sv]
`timescale 1ns/100ps
module lrm_top_tb_top;
  import lrm_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic general_pin_zero_in = 1'b0;
  logic [LRM_NUM_LDO-1:0] ldo_power_good_in = 9'h1ff;
  logic [LRM_NUM_LDO-1:0][LRM_LVL_W-1:0] ldo_sense_in = '0;
  logic [LRM_NUM_LDO-1:0] seq_enable_in = 9'h000;
  logic bias_out;
  logic global_bias_out;
  logic [LRM_NUM_LDO-1:0] ldo_on_out;
  logic [LRM_NUM_LDO-1:0][LRM_LVL_W-1:0] ldo_level_out;
  logic [LRM_NUM_LDO-1:0] ldo_low_power_out;
  logic [LRM_NUM_LDO-1:0] ldo_clamp_out;
  logic [LRM_NUM_BUCK-1:0] buck_low_power_out;
  logic ldo_summary_irq_out;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  logic [15:0] rnd_q = 16'h000e;
  logic [31:0] m_q;
  logic [31:0] rd_q;

  // Short slew steps keep the ramp checks to a few dozen cycles
  lrm_top #(.STEP_SLOW_CYC(20), .STEP_FAST_CYC(4)) u_lrm_top (.clock_in, .reset_in, .clk_en_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .general_pin_zero_in, .ldo_power_good_in, .ldo_sense_in,
    .seq_enable_in, .bias_out, .global_bias_out, .ldo_on_out, .ldo_level_out,
    .ldo_low_power_out, .ldo_clamp_out, .buck_low_power_out, .ldo_summary_irq_out);

  initial begin
    forever #20 clock_in = ~clock_in;
  end

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function logic [8:0] exp_lp(input logic [17:0] m, input logic g);
    logic [8:0] r;
    for (int i = 0; i < 9; i++) begin
      r[i] = (m[2*i+:2] == 2'b10) || ((m[2*i+:2] == 2'b01) && g);
    end
    return r;
  endfunction : exp_lp

  task complete_run;
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int k);
    repeat (k) @(posedge clock_in);
  endtask : cyc

  // Request held until the edge where waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    avs_address_in <= a;
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= d;
    do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
    rd_q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd_q, exp);
  endtask : rdc

  task wait_on(input int i);
    n = 0;
    while (ldo_on_out[i] !== 1'b1) begin
      cyc(1);
      n++;
    end
  endtask : wait_on

  initial begin
    cyc(20000);
    miscompares++;
    complete_run();
  end

  initial begin
    cyc(10);
    reset_in <= 1'b0;
    cyc(3);
    check(avs_waitrequest_out, 1'b1);
    check(ldo_clamp_out, 9'h1ff);
    rdc(LRM_OFS_CTRL, 32'h0);
    rdc(LRM_OFS_CLAMP, 32'h1ff);
    rdc(LRM_OFS_TOP_MASK, 32'h1);
    rdc(8'h3c, 32'h0);
    for (int k = 0; k < 12; k++) begin
      m_q = {rnd_q, lfsr(rnd_q)};
      rnd_q = lfsr(lfsr(rnd_q));
      if (k == 0) m_q = 32'h0002aaaa;
      if (k == 1) m_q = 32'h80015555;
      wr(LRM_OFS_CTRL, {30'h0, m_q[31], 1'b0});
      wr(LRM_OFS_LDO_MODE, {14'h0, m_q[17:0]});
      wr(LRM_OFS_BUCK_MODE, {24'h0, m_q[25:18]});
      wr(LRM_OFS_CLAMP, {23'h0, m_q[8:0] ^ m_q[26:18]});
      cyc(2);
      check(ldo_low_power_out, exp_lp(m_q[17:0], m_q[31]));
      check(buck_low_power_out, 9'h00f & exp_lp({10'h0, m_q[25:18]}, m_q[31]));
      check(ldo_clamp_out, (m_q[8:0] ^ m_q[26:18]) & ~exp_lp(m_q[17:0], m_q[31]));
    end
    wr(LRM_OFS_LDO_MODE, 32'h15555);
    wr(LRM_OFS_CTRL, 32'h6);
    cyc(6);
    check(ldo_low_power_out, 9'h000);
    general_pin_zero_in <= 1'b1;
    cyc(6);
    check(ldo_low_power_out, 9'h1ff);
    general_pin_zero_in <= 1'b0;
    wr(LRM_OFS_LDO_MODE, 32'h0);
    wr(LRM_OFS_CLAMP, 32'h1ff);
    wr(LRM_OFS_CTRL, 32'h1);
    cyc(2);
    check(bias_out, 1'b1);
    check(global_bias_out, 1'b1);
    wr(LRM_OFS_CTRL, 32'h0);
    cyc(2);
    check(bias_out, 1'b0);
    wr(LRM_OFS_SEQ_SLOT, 32'h2);
    wr(LRM_OFS_SW_EN, 32'h2);
    cyc(2);
    check(bias_out, 1'b0);
    seq_enable_in <= 9'h002;
    cyc(2);
    check(bias_out, 1'b1);
    seq_enable_in <= 9'h000;
    wr(LRM_OFS_SW_EN, 32'h0);
    wr(LRM_OFS_SEQ_SLOT, 32'h0);
    cyc(2);
    check(bias_out, 1'b0);
    ldo_sense_in[0] <= 8'h20;
    wr(LRM_OFS_TARGET, 32'h24);
    wr(LRM_OFS_SLEW, 32'h1);
    wr(LRM_OFS_SW_EN, 32'h1);
    wait_on(0);
    check(n >= 1745 && n <= 1765, 1'b1);
    check(ldo_level_out[0], 8'h20);
    cyc(30);
    check(ldo_level_out[0], 8'h24);
    wr(LRM_OFS_TARGET, 32'h22);
    cyc(20);
    check(ldo_level_out[0], 8'h22);
    wr(LRM_OFS_SLEW, 32'h0);
    wr(LRM_OFS_TARGET, 32'h23);
    cyc(8);
    check(ldo_level_out[0], 8'h22);
    cyc(30);
    check(ldo_level_out[0], 8'h23);
    wr(LRM_OFS_SW_EN, 32'h3);
    wait_on(1);
    check(n >= 495 && n <= 510, 1'b1);
    wr(LRM_OFS_SW_EN, 32'h0);
    cyc(2);
    check(ldo_on_out, 9'h000);
    wr(LRM_OFS_TOP_MASK, 32'h0);
    ldo_power_good_in[3] <= 1'b0;
    cyc(300);
    ldo_power_good_in[3] <= 1'b1;
    cyc(20);
    rdc(LRM_OFS_IRQ_FLAGS, 32'h0);
    ldo_power_good_in[3] <= 1'b0;
    cyc(700);
    rdc(LRM_OFS_IRQ_FLAGS, 32'h8);
    rdc(LRM_OFS_STATUS, 32'h1f7);
    check(ldo_summary_irq_out, 1'b1);
    rdc(LRM_OFS_TOP_IRQ, 32'h1);
    wr(LRM_OFS_TOP_MASK, 32'h1);
    cyc(2);
    check(ldo_summary_irq_out, 1'b0);
    ldo_power_good_in[3] <= 1'b1;
    cyc(700);
    rdc(LRM_OFS_IRQ_FLAGS, 32'h8);
    wr(LRM_OFS_IRQ_FLAGS, 32'h8);
    wr(LRM_OFS_TOP_MASK, 32'h0);
    cyc(2);
    check(ldo_summary_irq_out, 1'b0);
    rdc(LRM_OFS_IRQ_FLAGS, 32'h0);
    complete_run();
  end
endmodule : lrm_top_tb_top
